//--- src/qbp_port_block.sv
// five-port latch block with latch and pin read paths and bus override
`timescale 1ns/10ps
module qbp_port_block
  import qbp_pkg::*;
#(
  parameter int W   = PORT_W,
  parameter int EW  = PORT_E_W
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire qbp_pkg::qbp_op_t        cpuOp,
  input  wire logic [qbp_pkg::SEL_W-1:0] cpuSel,
  input  wire logic                    cpuBitOp,
  input  wire logic [2:0]              cpuBitIdx,
  input  wire logic                    cpuBitVal,
  input  wire logic [W-1:0]            cpuWrData,
  output      logic [W-1:0]            cpuRdData,
  output      logic                    devRst,
  input  wire logic                    busCycle,
  input  wire logic [W-1:0]            busAddrData,
  input  wire logic [W-1:0]            busAddrHigh,
  input  wire logic [W-1:0]            altOutB,
  input  wire logic [W-1:0]            altOutD,
  input  wire logic [EW-1:0]           altOutE,
  input  wire logic [W-1:0]            analogSelB,
  input  wire logic [W-1:0]            pinAIn,
  output      logic [W-1:0]            pinAOut,
  output      logic [W-1:0]            pinAOe,
  input  wire logic [W-1:0]            pinBIn,
  output      logic [W-1:0]            pinBOut,
  output      logic [W-1:0]            pinBOe,
  output      logic [W-1:0]            pinBBoost,
  input  wire logic [W-1:0]            pinCIn,
  output      logic [W-1:0]            pinCOut,
  output      logic [W-1:0]            pinCOe,
  output      logic [W-1:0]            pinCBoost,
  input  wire logic [W-1:0]            pinDIn,
  output      logic [W-1:0]            pinDOut,
  output      logic [W-1:0]            pinDOe,
  output      logic [W-1:0]            pinDBoost,
  input  wire logic [EW-1:0]           pinEIn,
  output      logic [EW-1:0]           pinEOut,
  output      logic [EW-1:0]           pinEOe,
  output      logic [EW-1:0]           pinEBoost
);
  import qbp_pkg::*;

  // ********************************************************
  // reset qualification
  // ********************************************************
  // reset pin arrives from outside: three flops, then a stable count
  logic             rstS1_ff;
  logic             rstS2_ff;
  logic             rstS3_ff;
  logic [CNT_W-1:0] rstCnt_ff;
  logic             devRst_ff;
  logic             rstHigh;

  always_ff @(posedge clk) begin
    rstS1_ff <= rst;
    rstS2_ff <= rstS1_ff;
    rstS3_ff <= rstS2_ff;
  end
  assign rstHigh = rstS2_ff & rstS3_ff;

  // asynchronous flop reset would make the two-cycle qualification moot;
  // only the reset counter and devRst use the qualified level
  always_ff @(posedge clk) begin
    if (!rstHigh) begin
      rstCnt_ff <= '0;
      devRst_ff <= 1'b0;
    end else if (rstCnt_ff == RST_LOAD) begin
      devRst_ff <= 1'b1;
    end else begin
      rstCnt_ff <= rstCnt_ff + 4'h1;
    end
  end
  assign devRst = devRst_ff;

  // ********************************************************
  // pin sampling
  // ********************************************************
  logic [NUM_PORTS*W-1:0] pinRaw;
  logic [NUM_PORTS*W-1:0] pinS1_ff;
  logic [NUM_PORTS*W-1:0] pinS2_ff;
  logic [NUM_PORTS*W-1:0] pinS3_ff;
  logic [NUM_PORTS*W-1:0] pinVal_ff;

  assign pinRaw = {{(W-EW){1'b0}}, pinEIn, pinDIn, pinCIn, pinBIn, pinAIn};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinS1_ff  <= '0;
      pinS2_ff  <= '0;
      pinS3_ff  <= '0;
      pinVal_ff <= '0;
    end else begin
      pinS1_ff <= pinRaw;
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      // a bit moves only once second and third stage agree
      pinVal_ff <= (pinS2_ff & pinS3_ff) | (pinVal_ff & (pinS2_ff | pinS3_ff));
    end
  end

  // ********************************************************
  // port latches
  // ********************************************************
  logic [W-1:0] latch_ff [NUM_PORTS];
  logic [W-1:0] latchSel;
  logic [W-1:0] pinSel;
  logic [W-1:0] bitMask;
  logic [W-1:0] bitByte;
  logic [W-1:0] newByte;
  logic         wrHit;
  logic         validSel;

  function automatic logic [W-1:0] decodeBit(input logic [2:0] idx);
    decodeBit = {{(W-1){1'b0}}, 1'b1} << idx;
  endfunction : decodeBit

  assign validSel = (cpuSel <= PORT_E);
  assign latchSel = validSel ? latch_ff[cpuSel] : '0;
  // out-of-range select reads zero instead of past the vector
  assign pinSel   = validSel ? pinVal_ff[cpuSel*W +: W] : '0;
  assign bitMask  = decodeBit(cpuBitIdx);
  // whole latch byte read, one bit changed, byte written back
  assign bitByte  = (latchSel & ~bitMask) | ({W{cpuBitVal}} & bitMask);
  assign newByte  = cpuBitOp ? bitByte : cpuWrData;
  assign wrHit    = validSel & ((cpuOp == QBP_WRITE) | (cpuOp == QBP_RMW));

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_latch
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          latch_ff[p] <= LATCH_RST;
        end else if (devRst_ff) begin
          latch_ff[p] <= LATCH_RST;
        end else if (wrHit && cpuSel == SEL_W'(p)) begin
          latch_ff[p] <= newByte;
        end
      end
      // the reload during devRst wins over any write
      port_write_a: assert property (
        @(posedge clk) disable iff (rst)
        (wrHit && !cpuBitOp && cpuSel == SEL_W'(p) && !devRst_ff)
        |=> latch_ff[p] == $past(cpuWrData))
        else $error("port latch missed write");
    end
  endgenerate

  // ********************************************************
  // read paths
  // ********************************************************
  logic [W-1:0] nxt_rdData;
  logic [W-1:0] rdData_ff;
  // rmw ops read latch, plain reads see the pin
  assign nxt_rdData = (cpuOp == QBP_RMW) ? latchSel :
                      (cpuOp == QBP_READ) ? pinSel : rdData_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end
  assign cpuRdData = rdData_ff;

  // ********************************************************
  // first port: open drain, bus drive during memory cycles
  // ********************************************************
  // software must keep off ports a and c while busCycle is high
  logic [W-1:0] aSrc;
  assign aSrc    = busCycle ? busAddrData : latch_ff[0];
  assign pinAOut = busCycle ? aSrc : '0;
  // ones driven strongly only during bus cycles, else released
  assign pinAOe  = busCycle ? {W{1'b1}} : ~aSrc;

  // ********************************************************
  // quasi-bidirectional ports
  // ********************************************************
  qbp_port_if #(.W(W))  ifB ();
  qbp_port_if #(.W(W))  ifC ();
  qbp_port_if #(.W(W))  ifD ();
  qbp_port_if #(.W(EW)) ifE ();

  assign ifB.latchQ  = latch_ff[1];
  assign ifB.altOut  = altOutB;
  assign ifB.pullOff = analogSelB;
  assign ifC.latchQ  = busCycle ? busAddrHigh : latch_ff[2];
  assign ifC.altOut  = {W{1'b1}};
  assign ifC.pullOff = '0;
  assign ifD.latchQ  = latch_ff[3];
  assign ifD.altOut  = altOutD;
  assign ifD.pullOff = '0;
  assign ifE.latchQ  = latch_ff[4][EW-1:0];
  assign ifE.altOut  = altOutE;
  assign ifE.pullOff = '0;

  qbp_quasi_drv #(.W(W))  uDrvB (.clk(clk), .rst(rst), .prt(ifB));
  qbp_quasi_drv #(.W(W))  uDrvC (.clk(clk), .rst(rst), .prt(ifC));
  qbp_quasi_drv #(.W(W))  uDrvD (.clk(clk), .rst(rst), .prt(ifD));
  qbp_quasi_drv #(.W(EW)) uDrvE (.clk(clk), .rst(rst), .prt(ifE));

  assign pinBOut   = ifB.pinHighOe;
  assign pinBOe    = ifB.pinLowOe | ifB.pinHighOe;
  assign pinBBoost = ifB.boostOn;
  assign pinCOut   = ifC.pinHighOe;
  assign pinCOe    = ifC.pinLowOe | ifC.pinHighOe;
  // strong pull-up held on for ones throughout a bus cycle
  assign pinCBoost = ifC.boostOn | (busCycle ? busAddrHigh : '0);
  assign pinDOut   = ifD.pinHighOe;
  assign pinDOe    = ifD.pinLowOe | ifD.pinHighOe;
  assign pinDBoost = ifD.boostOn;
  assign pinEOut   = ifE.pinHighOe;
  assign pinEOe    = ifE.pinLowOe | ifE.pinHighOe;
  assign pinEBoost = ifE.boostOn;

  // ********************************************************
  // checks
  // ********************************************************
  // write, bit-op and bad-select checks leave devRst cycles out: the reload there overrides writes
  latch_write_a: assert property (
    @(posedge clk) disable iff (rst)
    (cpuOp == QBP_WRITE && !cpuBitOp && cpuSel == PORT_B && !devRst_ff)
    |=> latch_ff[1] == $past(cpuWrData))
    else $error("port b latch missed write");
  bit_rmw_a: assert property (
    @(posedge clk) disable iff (rst)
    (cpuOp == QBP_RMW && cpuBitOp && cpuSel == PORT_D && !devRst_ff)
    |=> (latch_ff[3] & ~$past(bitMask)) ==
        ($past(latch_ff[3]) & ~$past(bitMask)))
    else $error("bit op disturbed other bits");
  bit_value_a: assert property (
    @(posedge clk) disable iff (rst)
    (cpuOp == QBP_RMW && cpuBitOp && cpuSel == PORT_D && !devRst_ff)
    |=> latch_ff[3][$past(cpuBitIdx)] == $past(cpuBitVal))
    else $error("bit op missed addressed bit");
  rmw_read_a: assert property (
    @(posedge clk) disable iff (rst)
    (cpuOp == QBP_RMW && cpuSel == PORT_C)
    |=> cpuRdData == $past(latch_ff[2]))
    else $error("rmw read did not use latch");
  pin_read_a: assert property (
    @(posedge clk) disable iff (rst)
    (cpuOp == QBP_READ && cpuSel == PORT_A)
    |=> cpuRdData == $past(pinVal_ff[W-1:0]))
    else $error("plain read did not use pin");
  // read data sits still between reads so software sees one value
  rd_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (cpuOp == QBP_NOP || cpuOp == QBP_WRITE)
    |=> $stable(cpuRdData))
    else $error("read data moved without a read");
  // out-of-range selects must not alias onto a real port
  bad_sel_a: assert property (
    @(posedge clk) disable iff (rst)
    (cpuSel > PORT_E && !devRst_ff)
    |=> latch_ff[0] == $past(latch_ff[0]) &&
        latch_ff[4] == $past(latch_ff[4]))
    else $error("bad select changed a latch");
  open_drain_a: assert property (
    @(posedge clk) disable iff (rst)
    !busCycle
    |-> pinAOut == '0 && pinAOe == ~latch_ff[0])
    else $error("port a not open drain");
  bus_route_a: assert property (
    @(posedge clk) disable iff (rst)
    busCycle
    |-> pinAOut == busAddrData && pinCOut == busAddrHigh)
    else $error("bus not routed to ports");
  // ones on port c get the strong pull-up for the whole bus cycle
  bus_boost_a: assert property (
    @(posedge clk) disable iff (rst)
    busCycle
    |-> (pinCBoost & busAddrHigh) == busAddrHigh)
    else $error("port c ones lack strong pull-up");
  low_side_a: assert property (
    @(posedge clk) disable iff (rst)
    (pinBOe & ~pinBOut) == ~(latch_ff[1] & altOutB))
    else $error("port b low driver wrong");
  alt_and_a: assert property (
    @(posedge clk) disable iff (rst)
    pinDOut == (latch_ff[3] & altOutD))
    else $error("port d alternate output not anded");
  // analog inputs must not see the pull-up current; the boost pull-up is not gated off
  pull_off_a: assert property (
    @(posedge clk) disable iff (rst)
    (pinBOut & analogSelB) == '0)
    else $error("pull-up left on analog pin");
  reset_load_a: assert property (
    @(posedge clk) disable iff (rst)
    devRst_ff
    |=> latch_ff[0] == LATCH_RST && latch_ff[4] == LATCH_RST)
    else $error("reset did not set latches");
  reset_qual_a: assert property (
    @(posedge clk)
    !rstHigh |=> !devRst_ff)
    else $error("reset taken without level");
  reset_take_a: assert property (
    @(posedge clk)
    (rstHigh && rstCnt_ff == RST_LOAD) |=> devRst_ff)
    else $error("qualified reset not taken");
endmodule : qbp_port_block

//--- src/qbp_pkg.sv
// constants, types and rule summary for the quasi-bidirectional port block
// Functional notes
// - write strobe captures bus into port latch
// - separate latch-read and pin-read paths
// - each bit independently input or output
// - latch zero pulls low, one releases
// - alternate output ANDed with latch bit
// - second port pull-up off when analog; the boost pull-up still fires on a rise
// - first port open-drain except bus cycles
// - bus cycle routes address/data to ports
// - third port strong pull-up in bus cycles
// - read-modify-write ops read the latch
// - bit ops rewrite whole latch byte
// - plain reads return sampled pin level
// - reset after two machine cycles high; latches also load ones as soon as rst rises
// - reset loads ones into all latches
// - boost pull-up two periods after rise
package qbp_pkg;
  localparam int PORT_W    = 8;
  localparam int PORT_E_W  = 5;
  localparam int NUM_PORTS = 5;
  localparam int SEL_W     = 3;
  // machine cycle is six clocks in the fast mode
  localparam int CLK_PER_MC   = 6;
  localparam int RST_MC       = 2;
  localparam int RST_CYC      = CLK_PER_MC * RST_MC;
  localparam int BOOST_CYC    = 2;
  localparam int CNT_W        = 4;
  localparam logic [CNT_W-1:0] BOOST_LOAD = 4'h2;
  localparam logic [CNT_W-1:0] RST_LOAD   = 4'hc;
  localparam logic [PORT_W-1:0] LATCH_RST = 8'hff;
  localparam logic [SEL_W-1:0] PORT_A = 3'h0;
  localparam logic [SEL_W-1:0] PORT_B = 3'h1;
  localparam logic [SEL_W-1:0] PORT_C = 3'h2;
  localparam logic [SEL_W-1:0] PORT_D = 3'h3;
  localparam logic [SEL_W-1:0] PORT_E = 3'h4;

  typedef enum logic [1:0] {
    QBP_NOP,
    QBP_WRITE,
    QBP_READ,
    QBP_RMW
  } qbp_op_t;
endpackage : qbp_pkg

//--- src/qbp_port_if.sv
// carrier between the port core and the driver slice of one quasi-bidirectional port
`timescale 1ns/10ps
interface qbp_port_if #(parameter int W = 8);
  logic [W-1:0] latchQ;
  logic [W-1:0] altOut;
  logic [W-1:0] pullOff;
  logic [W-1:0] pinLowOe;
  logic [W-1:0] pinHighOe;
  logic [W-1:0] boostOn;
  modport core (output latchQ, output altOut, output pullOff,
                input pinLowOe, input pinHighOe, input boostOn);
  modport drv  (input latchQ, input altOut, input pullOff,
                output pinLowOe, output pinHighOe, output boostOn);
endinterface : qbp_port_if

//--- src/qbp_quasi_drv.sv
// driver slice for one quasi-bidirectional port with transition boost
`timescale 1ns/10ps
module qbp_quasi_drv
  import qbp_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic    clk,
  input wire logic    rst,
  qbp_port_if.drv     prt
);
  import qbp_pkg::*;

  logic [W-1:0] effOut;
  logic [W-1:0] prevOut_ff;

  assign effOut = prt.latchQ & prt.altOut;
  // each bit has its own driver, no shared direction
  assign prt.pinLowOe = ~effOut;
  // weak pull-up modelled as high drive unless pull-up is switched off
  assign prt.pinHighOe = effOut & ~prt.pullOff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevOut_ff <= LATCH_RST[W-1:0];
    end else begin
      prevOut_ff <= effOut;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_boost
      logic [CNT_W-1:0] cnt_ff;
      logic             rise;
      assign rise = effOut[g] & ~prevOut_ff[g];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_ff <= '0;
        end else if (rise) begin
          // rise covers the first period itself, the counter the rest
          cnt_ff <= BOOST_LOAD - 4'h1;
        end else if (cnt_ff != '0) begin
          cnt_ff <= cnt_ff - 4'h1;
        end
      end
      assign prt.boostOn[g] = rise | (cnt_ff != '0);
      boost_len_a: assert property (
        @(posedge clk) disable iff (rst)
        rise |-> prt.boostOn[g] [*2] ##1 !prt.boostOn[g])
        else $error("boost not exactly two periods");
    end
  endgenerate

  low_drive_a: assert property (@(posedge clk) disable iff (rst)
    (prt.pinLowOe == ~(prt.latchQ & prt.altOut)))
    else $error("low driver mismatches latch");
endmodule : qbp_quasi_drv

//--- test/qbp_pin_model.sv
// outside world of one port: board drivers and floating lines
`timescale 1ns/10ps
module qbp_pin_model #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] drvOut,
  input  wire logic [W-1:0] drvOe,
  input  wire logic [W-1:0] extEn,
  input  wire logic [W-1:0] extVal,
  output      logic [W-1:0] pinLevel
);
  // ****
  // wired level
  // ****
  logic [W-1:0] floatPat_ff = '0;
  logic [W-1:0] lowDrv;
  logic [W-1:0] others;
  // no keeper on the board: a released line wanders every cycle
  always_ff @(posedge clk) floatPat_ff <= ~floatPat_ff;
  assign lowDrv   = drvOe & ~drvOut;
  assign others   = (extEn & extVal) | (~extEn & drvOe & drvOut);
  // the device low driver wins over any outside source
  assign pinLevel = ~lowDrv & (others | (~extEn & ~drvOe & floatPat_ff));
endmodule : qbp_pin_model

//--- test/qbp_port_block_test.sv
// self-checking bench for the five-port latch block
`timescale 1ns/10ps
module qbp_port_block_test;
  import qbp_pkg::*;
  // ****
  // signals
  // ****
  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        busCycle   = 1'b0;
  logic        cpuBitOp   = 1'b0;
  logic        cpuBitVal  = 1'b0;
  qbp_op_t     cpuOp      = QBP_NOP;
  logic [2:0]  cpuSel     = 3'h0;
  logic [2:0]  cpuBitIdx  = 3'h0;
  logic [7:0]  cpuWrData  = 8'h00;
  logic [7:0]  busAddrData = 8'h00;
  logic [7:0]  busAddrHigh = 8'h00;
  logic [7:0]  altOutB    = 8'hff;
  logic [7:0]  altOutD    = 8'hff;
  logic [4:0]  altOutE    = 5'h1f;
  logic [7:0]  analogSelB = 8'h00;
  logic [7:0]  extEn [5]  = '{default: 8'h00};
  logic [7:0]  extVal [5] = '{default: 8'h00};
  logic [7:0]  lat [5]    = '{default: 8'hff};
  logic [7:0]  pinIn [5], pinOut [5], pinOe [5], boost [5];
  logic [7:0]  cpuRdData;
  logic        devRst;
  logic [31:0] seed;
  int          n_errors   = 0;
  int          n_tests    = 0;

  qbp_port_block qbp_port_block_i (
    .clk(clk), .rst(rst), .cpuOp(cpuOp), .cpuSel(cpuSel),
    .cpuBitOp(cpuBitOp), .cpuBitIdx(cpuBitIdx), .cpuBitVal(cpuBitVal),
    .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .devRst(devRst),
    .busCycle(busCycle), .busAddrData(busAddrData),
    .busAddrHigh(busAddrHigh), .altOutB(altOutB), .altOutD(altOutD),
    .altOutE(altOutE), .analogSelB(analogSelB),
    .pinAIn(pinIn[0]), .pinAOut(pinOut[0]), .pinAOe(pinOe[0]),
    .pinBIn(pinIn[1]), .pinBOut(pinOut[1]), .pinBOe(pinOe[1]),
    .pinBBoost(boost[1]), .pinCIn(pinIn[2]), .pinCOut(pinOut[2]),
    .pinCOe(pinOe[2]), .pinCBoost(boost[2]), .pinDIn(pinIn[3]),
    .pinDOut(pinOut[3]), .pinDOe(pinOe[3]), .pinDBoost(boost[3]),
    .pinEIn(pinIn[4][4:0]), .pinEOut(pinOut[4][4:0]),
    .pinEOe(pinOe[4][4:0]), .pinEBoost(boost[4][4:0]));

  for (genvar p = 0; p < 5; p++) begin : g_pin
    qbp_pin_model qbp_pin_model_i (.clk(clk), .drvOut(pinOut[p]),
      .drvOe(pinOe[p]), .extEn(extEn[p]), .extVal(extVal[p]),
      .pinLevel(pinIn[p]));
  end

  initial begin
    forever #25 clk = ~clk;
  end

  // ****
  // helpers
  // ****
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed[7:0];
  endfunction : rnd

  // port e has only five pins; upper bits are never compared
  function automatic logic [7:0] m(input int p);
    return (p == 4) ? 8'h1f : 8'hff;
  endfunction : m

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic act(input qbp_op_t o, input logic [2:0] s,
      input logic b, input logic [2:0] i, input logic v,
      input logic [7:0] d);
    logic [7:0] old;
    old = (s < 3'h5) ? lat[s] & m(s) : 8'h00;
    @(posedge clk);
    cpuOp     <= o;
    cpuSel    <= s;
    cpuBitOp  <= b;
    cpuBitIdx <= i;
    cpuBitVal <= v;
    cpuWrData <= d;
    @(posedge clk);
    cpuOp     <= QBP_NOP;
    #1;
    if (o == QBP_RMW) chk(cpuRdData & m(s), old);
    if (o != QBP_READ && s < 3'h5) begin
      lat[s] = d;
      if (b) lat[s] = old | (~m(s) & d);
      if (b) lat[s][i] = v;
    end
  endtask : act

  task automatic pins(input int p);
    logic [7:0] e;
    logic [7:0] oe;
    e  = lat[p] & ((p == 1) ? altOutB : (p == 3) ? altOutD :
         (p == 4) ? {3'h0, altOutE} : 8'hff);
    oe = (p == 1) ? (~e | ~analogSelB) : (p == 0) ? ~lat[0] : m(p);
    chk(pinOe[p] & m(p), oe & m(p));
    chk(pinOut[p] & oe & m(p), (p == 0) ? 8'h00 : e & oe);
  endtask : pins

  task automatic waitRun();
    for (int k = 0; k < 60 && devRst !== 1'b0; k++) @(posedge clk);
    chk({7'h00, devRst}, 8'h00);
  endtask : waitRun

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // ****
  // main sequence
  // ****
  initial begin
    logic [2:0] s;
    seed = 32'h00bf51b9;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    waitRun();
    for (int p = 0; p < 5; p++) pins(p);
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      altOutB    <= rnd();
      altOutD    <= rnd();
      altOutE    <= 5'(rnd());
      analogSelB <= rnd();
      s = (k % 10 == 9) ? 3'(5 + k % 3) : 3'(rnd() % 8'h05);
      act(rnd() > 8'h7f ? QBP_WRITE : QBP_RMW, s, rnd() > 8'h7f,
          3'(rnd()), rnd() > 8'h7f, rnd());
      for (int p = 0; p < 5; p++) pins(p);
    end
    @(posedge clk);
    altOutB    <= 8'hff;
    altOutD    <= 8'hff;
    altOutE    <= 5'h1f;
    analogSelB <= 8'h00;
    for (int p = 1; p < 5; p++) begin
      act(QBP_WRITE, 3'(p), 1'b0, 3'h0, 1'b0, 8'h00);
      repeat (3) @(posedge clk);
      act(QBP_WRITE, 3'(p), 1'b0, 3'h0, 1'b0, 8'hff);
      for (int c = 0; c < 3; c++) begin
        chk(boost[p] & m(p), (c < 2) ? m(p) : 8'h00);
        @(posedge clk);
        #1;
      end
    end
    for (int p = 0; p < 5; p++) begin
      act(QBP_WRITE, 3'(p), 1'b0, 3'h0, 1'b0, rnd());
      extVal[p] <= rnd();
      extEn[p]  <= 8'hff;
      repeat (6) @(posedge clk);
      act(QBP_READ, 3'(p), 1'b0, 3'h0, 1'b0, 8'h00);
      chk(cpuRdData & m(p), extVal[p] & lat[p] & m(p));
      act(QBP_RMW, 3'(p), 1'b1, 3'h1, lat[p][1], 8'h00);
      extEn[p]  <= 8'h00;
    end
    // ports a and c untouched by the cpu during bus use
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      busCycle    <= 1'b1;
      busAddrData <= rnd();
      busAddrHigh <= rnd();
      @(posedge clk);
      #1;
      chk(pinOe[0], 8'hff);
      chk(pinOut[0], busAddrData);
      chk(pinOut[2], busAddrHigh);
      chk(boost[2] & busAddrHigh, busAddrHigh);
    end
    @(posedge clk);
    busCycle <= 1'b0;
    @(posedge clk);
    #1;
    pins(0);
    pins(2);
    act(QBP_WRITE, 3'h1, 1'b0, 3'h0, 1'b0, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (24) @(posedge clk);
    #1;
    chk({7'h00, devRst}, 8'h01);
    @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 5; p++) lat[p] = 8'hff;
    waitRun();
    for (int p = 0; p < 5; p++) pins(p);
    act(QBP_RMW, 3'h1, 1'b0, 3'h0, 1'b0, 8'hff);
    end_of_test();
  end
endmodule : qbp_port_block_test
